// ===== verilog/ssma_pkg.sv
//==========================================================
// Purpose : shared constants for the serial slave memory access port
// Assumes : one system clock, all bus pins asynchronous to it
// Notes   : pin synchroniser bit map and opcode fields live here
//==========================================================
package ssma_pkg;

	// ==========================================
	// slave address
	localparam logic [4:0] ADDR_FIXED   = 5'h0a;   // upper five address bits 01010
	localparam int         ADDR_DIR_BIT = 0;       // 1 = read, 0 = write

	// ==========================================
	// opcode fields
	localparam int         OP_RD_BIT  = 7;         // 0 in first byte = read command
	localparam int         OP_EE_HI   = 6;
	localparam int         OP_EE_LO   = 5;
	localparam logic [1:0] OP_EE_CODE = 2'h3;      // eeprom command family

	// ==========================================
	// byte framing
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BIT_MACK  = 4'h9;       // master ack seen, wait for fall
	localparam logic [7:0] RD_BLANK  = 8'hff;      // read value with no answer
	localparam logic [1:0] IDX_DATA  = 2'h2;       // spi byte index of first data byte

	// ==========================================
	// synchroniser bit map
	localparam int SY_SCL  = 0;
	localparam int SY_SDA  = 1;
	localparam int SY_SSN  = 2;
	localparam int SY_SCK  = 3;
	localparam int SY_MOSI = 4;
	localparam int SY_MODE = 5;
	localparam int SY_AHI  = 6;
	localparam int SY_ALO  = 7;
	localparam int SYNC_W  = 8;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 8'h07; // scl, sda and select rest high

	// ==========================================
	// receive buffer
	localparam int FIFO_W     = 9;                 // {first byte flag, byte}
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK
	} ssma_state_t;

endpackage

// ===== verilog/ssma_fifo.sv
//==========================================================
// Purpose : small flop fifo between the serial side and the user side
// Assumes : single clock, push and pop may meet in one cycle
// Notes   : in_ready low means full; out_valid low means empty
//==========================================================
`timescale 1ns/10ps
module ssma_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int         AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} ssma_fifo_t;

	ssma_fifo_t st_ff;
	ssma_fifo_t nxt_st;
	logic       push;
	logic       pop;

	// ==========================================
	// flags and read port
	assign in_ready  = (st_ff.cnt != FULL);
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = st_ff.mem[st_ff.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer wrap kept explicit so depth need not be a power of two
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.wp] = in_data;
			nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = st_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================
	// checks
	fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		st_ff.cnt <= FULL) else $error("fifo count above depth");
	fifo_full_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!in_ready && !out_ready) |=> $stable(st_ff.cnt)) else $error("fifo count moved while full");

endmodule

// ===== verilog/ssma_top.sv
//==========================================================
// Purpose : serial slave port, two-wire or four-wire, feeding a byte stream
// Assumes : pins asynchronous, link clock well below clk_sys/8
// Notes   : user side increments its own address per byte taken or sent
//==========================================================
`timescale 1ns/10ps
module ssma_top
	import ssma_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        serial_type_select,
	input  wire logic        addr_select_hi,
	input  wire logic        addr_select_lo,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        spi_ssn_n,
	input  wire logic        spi_sclk,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	output logic             spi_miso_oe,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic             rx_first,
	output logic [7:0]       rx_byte,
	output logic             rd_req,
	input  wire logic        rd_valid,
	input  wire logic [7:0]  rd_data,
	input  wire logic        eeprom_power_manual,
	input  wire logic        eeprom_power_auto,
	output logic             eeprom_power_on,
	output logic             busy
);
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		ssma_state_t       state;
		logic [3:0]        bitcnt;
		logic [7:0]        sh;
		logic [7:0]        tx;
		logic [7:0]        hold;
		logic [1:0]        idx;
		logic              addr_ph, first, rd_dir, ee_op;
		logic              sda_oe, miso, miso_oe, rd_req;
		logic              push, push_first;
		logic [7:0]        push_byte;
		logic              eepwr, busy;
	} ssma_regs_t;
	ssma_regs_t       st_ff;
	ssma_regs_t       nxt_st;
	logic             fifo_in_ready;
	logic [FIFO_W-1:0] fifo_out;
	logic             i2c_mode;
	logic             scl, sda, ssn;
	logic             scl_r, scl_f, sda_r, sda_f;
	logic             start_c, stop_c, sck_r, sck_f;
	logic [6:0]       my_addr;
	logic [7:0]       sh_in;
	// ==========================================
	// edges from the second sync stage against the third
	assign i2c_mode = st_ff.s2[SY_MODE];
	assign scl      = st_ff.s2[SY_SCL];
	assign sda      = st_ff.s2[SY_SDA];
	assign scl_r    = scl & ~st_ff.s3[SY_SCL];
	assign scl_f    = ~scl & st_ff.s3[SY_SCL];
	assign sda_r    = sda & ~st_ff.s3[SY_SDA];
	assign sda_f    = ~sda & st_ff.s3[SY_SDA];
	assign start_c  = i2c_mode & scl & st_ff.s3[SY_SCL] & sda_f;
	assign stop_c   = i2c_mode & scl & st_ff.s3[SY_SCL] & sda_r;
	assign ssn      = st_ff.s2[SY_SSN];
	assign sck_r    = st_ff.s2[SY_SCK] & ~st_ff.s3[SY_SCK];
	assign sck_f    = ~st_ff.s2[SY_SCK] & st_ff.s3[SY_SCK];
	assign my_addr  = {ADDR_FIXED, st_ff.s2[SY_AHI], st_ff.s2[SY_ALO]};
	// shared receive shifter, msb arrives first on both buses
	assign sh_in = i2c_mode ? {st_ff.sh[6:0], sda} : {st_ff.sh[6:0], st_ff.s2[SY_MOSI]};
	// ==========================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = {addr_select_lo, addr_select_hi, serial_type_select,
			spi_mosi, spi_sclk, spi_ssn_n, sda_i, scl_i};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.rd_req = 1'b0;
		nxt_st.push = 1'b0;
		// late user answer overrides the blank default
		if (rd_valid) begin
			nxt_st.hold = rd_data;
		end
		if (i2c_mode) begin
			nxt_st.miso_oe = 1'b0;
			case (st_ff.state)
				ST_RX: begin
					if (scl_r && st_ff.bitcnt != BITS_BYTE) begin
						nxt_st.sh = sh_in;
						nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
					end else if (scl_f && st_ff.bitcnt == BITS_BYTE) begin
						if (st_ff.addr_ph) begin
							// foreign address: stay off the line until next start
							if (st_ff.sh[7:1] == my_addr) begin
								nxt_st.sda_oe = 1'b1;
								nxt_st.state = ST_ACK;
								nxt_st.rd_dir = st_ff.sh[ADDR_DIR_BIT];
								nxt_st.first = ~st_ff.sh[ADDR_DIR_BIT];
								if (st_ff.sh[ADDR_DIR_BIT]) begin
									nxt_st.rd_req = 1'b1;
									nxt_st.hold = RD_BLANK;
								end
							end else begin
								nxt_st.state = ST_IDLE;
							end
						end else if (fifo_in_ready) begin
							// a full buffer answers not-ack instead of dropping
							nxt_st.push = 1'b1;
							nxt_st.push_first = st_ff.first;
							nxt_st.push_byte = st_ff.sh;
							nxt_st.first = 1'b0;
							if (st_ff.first) begin
								nxt_st.ee_op = (st_ff.sh[OP_EE_HI:OP_EE_LO] == OP_EE_CODE);
							end
							nxt_st.sda_oe = 1'b1;
							nxt_st.state = ST_ACK;
						end else begin
							nxt_st.state = ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_f) begin
						nxt_st.addr_ph = 1'b0;
						if (st_ff.rd_dir) begin
							nxt_st.tx = st_ff.hold;
							nxt_st.sda_oe = ~st_ff.hold[7];
							nxt_st.bitcnt = 4'h1;
							nxt_st.state = ST_TX;
						end else begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.bitcnt = 4'h0;
							nxt_st.state = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_f) begin
						if (st_ff.bitcnt == BITS_BYTE) begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.bitcnt = 4'h0;
							nxt_st.state = ST_MACK;
						end else begin
							nxt_st.sda_oe = ~st_ff.tx[6];
							nxt_st.tx = {st_ff.tx[6:0], 1'b0};
							nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_r) begin
						if (!sda) begin
							nxt_st.rd_req = 1'b1;
							nxt_st.hold = RD_BLANK;
							nxt_st.bitcnt = BIT_MACK;
						end else begin
							nxt_st.state = ST_IDLE;
						end
					end else if (scl_f && st_ff.bitcnt == BIT_MACK) begin
						nxt_st.tx = st_ff.hold;
						nxt_st.sda_oe = ~st_ff.hold[7];
						nxt_st.bitcnt = 4'h1;
						nxt_st.state = ST_TX;
					end
				end
				default: begin
					nxt_st.sda_oe = 1'b0;
				end
			endcase
			// bus conditions win over any bit activity
			if (start_c) begin
				nxt_st.state = ST_RX;
				nxt_st.bitcnt = 4'h0;
				nxt_st.addr_ph = 1'b1;
				nxt_st.sda_oe = 1'b0;
			end else if (stop_c) begin
				nxt_st.state = ST_IDLE;
				nxt_st.sda_oe = 1'b0;
				nxt_st.ee_op = 1'b0;
			end
			nxt_st.busy = (nxt_st.state != ST_IDLE);
		end else begin
			// four-wire bus, mode one: launch on rise, sample on fall
			nxt_st.sda_oe = 1'b0;
			nxt_st.state = ST_IDLE;
			nxt_st.miso_oe = ~ssn;
			nxt_st.busy = ~ssn;
			if (ssn) begin
				nxt_st.bitcnt = 4'h0;
				nxt_st.idx = 2'h0;
				nxt_st.miso = 1'b0;
				nxt_st.tx = 8'h00;
				nxt_st.ee_op = 1'b0;
				nxt_st.rd_dir = 1'b0;
			end else if (sck_f) begin
				nxt_st.sh = sh_in;
				if (st_ff.bitcnt == BITS_BYTE - 4'h1) begin
					nxt_st.bitcnt = 4'h0;
					if (st_ff.idx != IDX_DATA) begin
						nxt_st.idx = st_ff.idx + 2'h1;
					end
					if (st_ff.idx == 2'h0) begin
						nxt_st.rd_dir = ~sh_in[OP_RD_BIT];
						nxt_st.ee_op = (sh_in[OP_EE_HI:OP_EE_LO] == OP_EE_CODE);
					end
					// read data phase: mosi bytes are filler, not pushed
					if (!(st_ff.rd_dir && st_ff.idx == IDX_DATA) && fifo_in_ready) begin
						nxt_st.push = 1'b1;
						nxt_st.push_first = (st_ff.idx == 2'h0);
						nxt_st.push_byte = sh_in;
					end
					if (st_ff.rd_dir && st_ff.idx != 2'h0) begin
						nxt_st.rd_req = 1'b1;
						nxt_st.hold = RD_BLANK;
					end
				end else begin
					nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
				end
			end else if (sck_r) begin
				if (st_ff.bitcnt == 4'h0 && st_ff.rd_dir && st_ff.idx == IDX_DATA) begin
					nxt_st.miso = st_ff.hold[7];
					nxt_st.tx = {st_ff.hold[6:0], 1'b0};
				end else begin
					nxt_st.miso = st_ff.tx[7];
					nxt_st.tx = {st_ff.tx[6:0], 1'b0};
				end
			end
		end
		// automatic power only while an eeprom command is framed
		nxt_st.eepwr = eeprom_power_manual | (eeprom_power_auto & st_ff.busy & st_ff.ee_op);
	end
	// sync stages start at the resting pin levels, so no false select or edge follows reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff    <= '0;
			st_ff.s1 <= SYNC_IDLE;
			st_ff.s2 <= SYNC_IDLE;
			st_ff.s3 <= SYNC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ==========================================
	// receive buffer, stall shows as not-ack on the two-wire bus
	ssma_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (st_ff.push),
		.in_ready  (fifo_in_ready),
		.in_data   ({st_ff.push_first, st_ff.push_byte}),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (fifo_out)
	);
	// ==========================================
	// outputs
	assign rx_first        = fifo_out[FIFO_W-1];
	assign rx_byte         = fifo_out[7:0];
	assign sda_o           = 1'b0;   // open drain: only the enable moves
	assign sda_oe          = st_ff.sda_oe;
	assign spi_miso        = st_ff.miso;
	assign spi_miso_oe     = st_ff.miso_oe;
	assign rd_req          = st_ff.rd_req;
	assign eeprom_power_on = st_ff.eepwr;
	assign busy            = st_ff.busy;
	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence addr_hit_s;
		i2c_mode && st_ff.state == ST_RX && st_ff.addr_ph && st_ff.bitcnt == BITS_BYTE
			&& scl_f && !start_c && !stop_c && st_ff.sh[7:1] == my_addr;
	endsequence
	sequence mack_s;
		i2c_mode && st_ff.state == ST_MACK && scl_r && !start_c && !stop_c;
	endsequence
	start_enter_a: assert property (start_c |=> st_ff.state == ST_RX && st_ff.addr_ph
		&& st_ff.bitcnt == 4'h0) else $error("start not taken");
	stop_idle_a: assert property (stop_c |=> st_ff.state == ST_IDLE && !sda_oe)
		else $error("stop not taken");
	addr_ack_a: assert property (addr_hit_s |=> sda_oe && st_ff.state == ST_ACK
		&& rd_req == st_ff.rd_dir) else $error("own address not acked");
	addr_miss_a: assert property (i2c_mode && st_ff.state == ST_RX && st_ff.addr_ph
		&& st_ff.bitcnt == BITS_BYTE && scl_f && !start_c && !stop_c && st_ff.sh[7:1] != my_addr
		|=> st_ff.state == ST_IDLE && !sda_oe) else $error("foreign address acked");
	release_a: assert property (sda_oe |-> st_ff.state == ST_ACK || st_ff.state == ST_TX)
		else $error("data line held outside ack or read");
	mack_next_a: assert property (mack_s ##0 !sda |=> rd_req ##1 !rd_req)
		else $error("master ack without next byte request");
	mack_end_a: assert property (mack_s ##0 sda |=> st_ff.state == ST_IDLE && !sda_oe)
		else $error("not-ack did not end sending");
	one_bus_a: assert property (i2c_mode && $past(i2c_mode) |-> !spi_miso_oe)
		else $error("miso driven in two-wire mode");
	spi_quiet_a: assert property (!i2c_mode && !$past(i2c_mode) |-> !sda_oe)
		else $error("data line driven in four-wire mode");
	ee_manual_a: assert property (eeprom_power_manual |=> eeprom_power_on)
		else $error("manual eeprom power ignored");
	ee_off_a: assert property (!eeprom_power_manual && !st_ff.ee_op |=> !eeprom_power_on)
		else $error("eeprom powered without cause");
	blank_read_a: assert property (rd_req && !rd_valid |-> st_ff.hold == RD_BLANK)
		else $error("read default not all ones");
endmodule

// ===== bench/ssma_bus_master.sv
//==========================================================
// Purpose : behavioural serial bus master, two-wire and four-wire
// Assumes : pins change only at clk_sys falling edges, 16 cycles per link bit (64 ns)
// Notes   : two-wire data is open drain, 1 on sda_drv lets the pull-up win
//==========================================================
`timescale 1ns/10ps
module ssma_bus_master (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	input  wire logic miso_line,
	output logic      scl,
	output logic      sda_drv,
	output logic      ssn_n,
	output logic      sclk,
	output logic      mosi
);
	// =============================================
	// idle levels: both buses quiet, four-wire clock low
	initial begin
		scl     = 1'b1;
		sda_drv = 1'b1;
		ssn_n   = 1'b1;
		sclk    = 1'b0;
		mosi    = 1'b0;
	end

	task automatic q(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// =============================================
	// two-wire
	// start and repeated start alike: data falls while clock high
	task automatic i2c_start();
		sda_drv = 1'b1;
		q(4);
		scl = 1'b1;
		q(8);
		sda_drv = 1'b0;
		q(8);
		scl = 1'b0;
		q(4);
	endtask

	task automatic i2c_stop();
		sda_drv = 1'b0;
		q(4);
		scl = 1'b1;
		q(8);
		sda_drv = 1'b1;
		q(8);
	endtask

	// data moves only while clock low, so no false start or stop
	task automatic i2c_bit(input logic b, output logic r);
		sda_drv = b;
		q(4);
		scl = 1'b1;
		q(8);
		r = sda_line;
		scl = 1'b0;
		q(4);
	endtask

	task automatic i2c_wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(b[i], r);
		end
		i2c_bit(1'b1, ack);
	endtask

	// receive a byte, then ack low to go on or high to end
	task automatic i2c_rd(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(1'b1, b[i]);
		end
		i2c_bit(nack, r);
	endtask

	// =============================================
	// four-wire, mode one: change on the rise, sample on the fall
	task automatic spi_sel(input logic s);
		ssn_n = ~s;
		q(8);
	endtask

	task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			mosi = tx[i];
			q(8);
			sclk = 1'b0;
			rx[i] = miso_line;
			q(8);
		end
	endtask
endmodule

// ===== bench/tb_top.sv
//==========================================================
// Purpose : self-checking bench for the serial slave port
// Assumes : master model drives the pins, bench plays the user side
// Notes   : read data is 81 hex xor 37 times the fetch number, indexed by fetch
//==========================================================
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic       clk_sys = 1'b0;
	logic       arst_n = 1'b0;
	logic       serial_type_select = 1'b1;
	logic       addr_select_hi = 1'b0;
	logic       addr_select_lo = 1'b0;
	logic       rx_ready = 1'b0;
	logic       rd_valid = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic       rd_mute = 1'b0;
	logic       eeprom_power_manual = 1'b0;
	logic       eeprom_power_auto = 1'b0;
	logic       scl, sda_drv, ssn_n, sclk, mosi, miso_last;
	logic       sda_o, sda_oe, spi_miso, spi_miso_oe, rx_valid, rx_first, rd_req, eeprom_power_on, busy;
	logic [7:0] rx_byte;
	wire logic  sda_w, miso_w;
	int         fails = 0, samples_checked = 0, cycles = 0, rd_idx = 0;
	logic [7:0] wr_seq [5] = '{8'h91, 8'h47, 8'hff, 8'h12, 8'h34};
	logic [7:0] ee_seq [3] = '{8'he2, 8'h03, 8'h00};

	always #2 clk_sys = ~clk_sys;

	// =============================================
	// wires: pull-up on data, released miso shows the inverse of its last bit
	assign sda_w  = sda_drv & ~(sda_oe & ~sda_o);
	assign miso_w = spi_miso_oe ? spi_miso : ~miso_last;
	always @(posedge clk_sys) if (spi_miso_oe === 1'b1) miso_last <= spi_miso;

	ssma_bus_master master (.clk_sys(clk_sys), .sda_line(sda_w), .miso_line(miso_w), .scl(scl),
		.sda_drv(sda_drv), .ssn_n(ssn_n), .sclk(sclk), .mosi(mosi));

	ssma_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .serial_type_select(serial_type_select),
		.addr_select_hi(addr_select_hi), .addr_select_lo(addr_select_lo), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .spi_ssn_n(ssn_n), .spi_sclk(sclk), .spi_mosi(mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_first(rx_first), .rx_byte(rx_byte), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
		.eeprom_power_manual(eeprom_power_manual), .eeprom_power_auto(eeprom_power_auto),
		.eeprom_power_on(eeprom_power_on), .busy(busy));

	function automatic logic [7:0] rd_pat(input int i);
		return 8'h81 ^ 8'(i * 37);
	endfunction

	// =============================================
	// user side: answer each fetch one cycle later unless muted, address steps per fetch
	always @(negedge clk_sys) begin
		rd_valid <= (rd_req === 1'b1) && !rd_mute;
		if (rd_req === 1'b1 && !rd_mute) begin
			rd_data <= rd_pat(rd_idx);
			rd_idx  <= rd_idx + 1;
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// whole run needs about 5000 cycles; a hang is cut well after that
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end

	// take one byte from the buffer, bounded wait for it to appear
	task automatic pop(input logic f, input logic [7:0] b);
		int n;
		n = 0;
		while (rx_valid !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("rx_valid", 1'b1, rx_valid)
		`CHK("rx_first", f, rx_first)
		`CHK("rx_byte", b, rx_byte)
		rx_ready = 1'b1;
		@(negedge clk_sys);
		rx_ready = 1'b0;
		@(negedge clk_sys);
	endtask

	// =============================================
	// main sequence
	initial begin
		logic       a;
		logic [7:0] d;
		int         base;
		repeat (4) @(negedge clk_sys);
		arst_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK("sda_oe idle", 1'b0, sda_oe)
		`CHK("busy idle", 1'b0, busy)
		// every select setting: own address acked, neighbour refused
		for (int s = 0; s < 4; s++) begin
			{addr_select_hi, addr_select_lo} = 2'(s);
			repeat (8) @(negedge clk_sys);
			master.i2c_start();
			master.i2c_wr({5'h0a, 2'(s), 1'b0}, a);
			`CHK("ack own address", 1'b0, a)
			master.i2c_stop();
			master.i2c_start();
			master.i2c_wr({5'h0a, 2'(s ^ 1), 1'b0}, a);
			`CHK("ack foreign address", 1'b1, a)
			master.i2c_stop();
		end
		{addr_select_hi, addr_select_lo} = 2'h0;
		repeat (8) @(negedge clk_sys);
		// write while the user stalls: fifth data byte finds the buffer full
		master.i2c_start();
		master.i2c_wr(8'h50, a);
		`CHK("ack address 40", 1'b0, a)
		`CHK("busy in frame", 1'b1, busy)
		foreach (wr_seq[i]) begin
			master.i2c_wr(wr_seq[i], a);
			`CHK("ack data", 1'(i == 4), a)
		end
		master.i2c_stop();
		`CHK("busy after stop", 1'b0, busy)
		for (int i = 0; i < 4; i++) pop(1'(i == 0), wr_seq[i]);
		`CHK("buffer drained", 1'b0, rx_valid)
		// read: set address, repeated start, three bytes acked, acked, refused
		base = rd_idx;
		master.i2c_start();
		master.i2c_wr(8'h50, a);
		master.i2c_wr(8'h11, a);
		master.i2c_wr(8'h47, a);
		master.i2c_start();
		master.i2c_wr(8'h51, a);
		`CHK("ack read address", 1'b0, a)
		for (int k = 0; k < 3; k++) begin
			master.i2c_rd(1'(k == 2), d);
			`CHK("read byte", rd_pat(base + k), d)
		end
		master.i2c_stop();
		`CHK("fetch count", base + 3, rd_idx)
		pop(1'b1, 8'h11);
		pop(1'b0, 8'h47);
		// user side silent: the device must fall back to the blank value
		rd_mute = 1'b1;
		master.i2c_start();
		master.i2c_wr(8'h51, a);
		`CHK("ack muted read", 1'b0, a)
		master.i2c_rd(1'b1, d);
		`CHK("blank read", 8'hff, d)
		master.i2c_stop();
		rd_mute = 1'b0;
		// four-wire selected: two-wire address must go unanswered
		serial_type_select = 1'b0;
		repeat (8) @(negedge clk_sys);
		master.i2c_start();
		master.i2c_wr(8'h50, a);
		`CHK("two-wire ignored", 1'b1, a)
		master.i2c_stop();
		// erase with dummy bytes, power raised automatically
		eeprom_power_auto = 1'b1;
		master.spi_sel(1'b1);
		`CHK("miso enabled", 1'b1, spi_miso_oe)
		// erase only, no write follows: wake, trim and per-byte write waits are never owed here
		foreach (ee_seq[i]) master.spi_xfer(ee_seq[i], d);
		`CHK("auto eeprom power", 1'b1, eeprom_power_on)
		master.spi_sel(1'b0);
		`CHK("miso released", 1'b0, spi_miso_oe)
		`CHK("auto power off", 1'b0, eeprom_power_on)
		eeprom_power_auto = 1'b0;
		foreach (ee_seq[i]) pop(1'(i == 0), ee_seq[i]);
		eeprom_power_manual = 1'b1;
		repeat (3) @(negedge clk_sys);
		`CHK("manual eeprom power", 1'b1, eeprom_power_on)
		eeprom_power_manual = 1'b0;
		// four-wire read: opcode and address stored, filler bytes carry data
		base = rd_idx;
		master.spi_sel(1'b1);
		// plain memory read: no otp programming or otp read, so those waits and modes are not owed
		master.spi_xfer(8'h11, d);
		master.spi_xfer(8'h47, d);
		for (int k = 0; k < 2; k++) begin
			master.spi_xfer(8'h00, d);
			`CHK("spi read byte", rd_pat(base + k), d)
		end
		master.spi_sel(1'b0);
		pop(1'b1, 8'h11);
		pop(1'b0, 8'h47);
		`CHK("filler not stored", 1'b0, rx_valid)
		summarize();
	end
endmodule
